// ---- rtl/ios_internal_osc_select_switch.sv ----
// Design decisions made here: register access over Avalon-MM and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "ios_regs.svh"

module ios_internal_osc_select_switch #(
  parameter logic [31:0] LF_START_CYC   = 32'(`IOS_LF_START_CYC),
  parameter logic [31:0] MULT_LOCK_CYC  = 32'(`IOS_MULT_LOCK_CYC),
  parameter logic [31:0] FREQ_TAB [0:15] = '{
    32'h0000_7918, 32'h0000_7A12, 32'h0000_7A12, 32'h0000_7A12,
    32'h0000_F424, 32'h0001_E848, 32'h0003_D090, 32'h0007_A120,
    32'h0001_E848, 32'h0003_D090, 32'h0007_A120, 32'h000F_4240,
    32'h001E_8480, 32'h003D_0900, 32'h007A_1200, 32'h00F4_2400},
  parameter ios_pkg::ios_src_t SRC_TAB [0:15] = '{
    ios_pkg::IOS_SRC_LF, ios_pkg::IOS_SRC_MF, ios_pkg::IOS_SRC_MF,
    ios_pkg::IOS_SRC_HF, ios_pkg::IOS_SRC_MF, ios_pkg::IOS_SRC_MF,
    ios_pkg::IOS_SRC_MF, ios_pkg::IOS_SRC_MF, ios_pkg::IOS_SRC_HF,
    ios_pkg::IOS_SRC_HF, ios_pkg::IOS_SRC_HF, ios_pkg::IOS_SRC_HF,
    ios_pkg::IOS_SRC_HF, ios_pkg::IOS_SRC_HF, ios_pkg::IOS_SRC_HF,
    ios_pkg::IOS_SRC_HF}
) (
  input  wire logic             sys_clk_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  input  wire ios_pkg::ios_cfg_t cfg_i,
  input  wire logic             wdt_en_i,
  input  wire logic             failsafe_clock_monitor_en_i,
  input  wire logic             sec_gpio_d_i,
  input  wire logic             sec_gpio_oe_i,
  input  wire logic [3:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic [31:0]           avs_readdata_o,
  output logic                  avs_waitrequest_o,
  output logic                  int_clk_o,
  output logic                  lf_clk_o,
  output logic                  sec_pin_o,
  output logic                  sec_pin_oe_o,
  output logic                  prim_pin_gpio_o,
  output ios_pkg::ios_status_t  status_o
);
  import ios_pkg::*;

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Trim scales the step by 1/128 per code, about +-12 % overall
  function automatic logic [31:0] apply_trim(input logic [31:0] base,
                                             input logic [4:0]  trim);
    logic signed [31:0] d;
    d = 32'($signed({1'b0, base[31:7]})) * 32'($signed(trim));
    return base + 32'(d);
  endfunction

  function automatic logic [31:0] count_up(input logic [31:0] c);
    return (c == 32'hFFFF_FFFF) ? c : c + 32'h0000_0001;
  endfunction

  // --------------------------------------------------------------------
  // Frequency table to phase step
  // --------------------------------------------------------------------
  logic [31:0] inc_tab [0:15];
  for (genvar g = 0; g < 16; g++)
  begin : g_inc
    localparam logic [31:0] INC =
      32'((64'(FREQ_TAB[g]) << 32) / `IOS_CLK_HZ);
    assign inc_tab[g] = INC;
  end

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  ios_ctrl_t   ctrl_reg, ctrl_next;
  logic [4:0]  trim_reg, trim_next;
  logic [4:0]  trim_eff_reg, trim_eff_next;
  logic [31:0] trim_cnt_reg, trim_cnt_next;
  logic        wait_reg, wait_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [31:0] start_cnt_reg [0:2];
  logic [31:0] start_cnt_next [0:2];
  logic [2:0]  rdy_reg, rdy_next;
  logic [31:0] hf_age_reg, hf_age_next;
  logic [31:0] mult_cnt_reg, mult_cnt_next;
  logic        mult_lock_reg, mult_lock_next;
  ios_state_t  state_reg, state_next;
  logic [3:0]  cur_sel_reg, cur_sel_next;
  logic [3:0]  tgt_sel_reg, tgt_sel_next;
  logic [31:0] acc_reg, acc_next;
  logic [31:0] lf_acc_reg, lf_acc_next;
  logic        gate_reg, gate_next;
  logic [1:0]  gate_sync_reg, gate_sync_next;
  logic        clk_out_next;
  logic        sec_pin_next, sec_oe_next, prim_next;
  ios_status_t status_next;

  logic        int_mode, mult_on, tgt_ready;
  logic [2:0]  osc_en;
  ios_src_t    src_c, src_t;
  logic [31:0] inc_cur, start_len [0:2];
  logic        req, hit_ctrl, hit_trim, hit_stat;

  // Internal block drives the clock for config 100 or select 1x
  assign int_mode = (cfg_i.osc_config_sel == `IOS_CFG_INTERNAL) ||
                    ctrl_reg.sys_clk_source_sel[1];
  assign mult_on  = cfg_i.cfg_multiplier_enable ||
                    ctrl_reg.sw_multiplier_enable;
  assign src_c    = SRC_TAB[cur_sel_reg];
  assign src_t    = SRC_TAB[tgt_sel_reg];
  assign start_len[IOS_SRC_LF] = LF_START_CYC;
  assign start_len[IOS_SRC_MF] = 32'(`IOS_MF_START_CYC);
  assign start_len[IOS_SRC_HF] = 32'(`IOS_HF_START_CYC);

  // --------------------------------------------------------------------
  // Oscillator enables and start-up
  // --------------------------------------------------------------------
  // Old source stays on until the switch lets go of it
  always_comb
  begin
    osc_en = 3'b000;
    for (int i = 0; i < 3; i++)
      osc_en[i] = int_mode &&
                  (src_t == ios_src_t'(i) ||
                   (state_reg != IOS_ST_IDLE && src_c == ios_src_t'(i)));
    osc_en[IOS_SRC_MF] = osc_en[IOS_SRC_MF] ||
                         osc_en[IOS_SRC_HF];
    osc_en[IOS_SRC_LF] = osc_en[IOS_SRC_LF] ||
                         wdt_en_i || failsafe_clock_monitor_en_i;
  end

  // HF needs its MF reference running; PLL lock counts only while on
  always_comb
  begin
    rdy_next      = rdy_reg;
    hf_age_next   = hf_age_reg;
    mult_cnt_next = mult_cnt_reg;
    mult_lock_next = mult_lock_reg;
    for (int i = 0; i < 3; i++)
    begin
      start_cnt_next[i] = start_cnt_reg[i];
      if (!osc_en[i])
      begin
        start_cnt_next[i] = 32'h0000_0000;
        rdy_next[i]       = 1'b0;
      end
      else if (!rdy_reg[i])
      begin
        start_cnt_next[i] = count_up(start_cnt_reg[i]);
        rdy_next[i] = (start_cnt_next[i] >= start_len[i]);
      end
    end
    if (!rdy_reg[IOS_SRC_MF])
      rdy_next[IOS_SRC_HF] = 1'b0;
    hf_age_next = rdy_reg[IOS_SRC_HF] ? count_up(hf_age_reg) : 32'h0;
    if (mult_on && rdy_reg[IOS_SRC_HF])
    begin
      mult_cnt_next  = count_up(mult_cnt_reg);
      mult_lock_next = (mult_cnt_next >= MULT_LOCK_CYC);
    end
    else
    begin
      mult_cnt_next  = 32'h0000_0000;
      mult_lock_next = 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // Trim slew
  // --------------------------------------------------------------------
  // One code step per interval so the frequency glides, no done flag
  always_comb
  begin
    trim_eff_next = trim_eff_reg;
    trim_cnt_next = trim_cnt_reg;
    if (trim_eff_reg != trim_reg)
    begin
      trim_cnt_next = trim_cnt_reg + 32'h0000_0001;
      if (trim_cnt_reg >= 32'(`IOS_TRIM_STEP_CYC) - 32'h1)
      begin
        trim_cnt_next = 32'h0000_0000;
        if ($signed(trim_eff_reg) < $signed(trim_reg))
          trim_eff_next = trim_eff_reg + 5'h01;
        else
          trim_eff_next = trim_eff_reg - 5'h01;
      end
    end
    else
      trim_cnt_next = 32'h0000_0000;
  end

  // --------------------------------------------------------------------
  // Clock synthesis and switch sequence
  // --------------------------------------------------------------------
  // LF path never sees trim; multiplier scales the other paths by four
  always_comb
  begin
    inc_cur = inc_tab[cur_sel_reg];
    if (src_c != IOS_SRC_LF)
    begin
      inc_cur = apply_trim(inc_cur, trim_eff_reg);
      if (mult_on)
        inc_cur = {inc_cur[29:0], 2'b00};
    end
  end

  assign tgt_ready = rdy_reg[src_t] &&
                     (src_t == IOS_SRC_LF || !mult_on || mult_lock_reg);

  always_comb
  begin
    state_next     = state_reg;
    cur_sel_next   = cur_sel_reg;
    tgt_sel_next   = tgt_sel_reg;
    gate_next      = gate_reg;
    gate_sync_next = gate_sync_reg;
    acc_next       = acc_reg + inc_cur;
    lf_acc_next    = rdy_reg[IOS_SRC_LF] ?
                     lf_acc_reg + inc_tab[0] : 32'h0;
    case (state_reg)
      IOS_ST_IDLE:
        if (int_mode && ctrl_reg.internal_freq_sel != cur_sel_reg)
        begin
          tgt_sel_next = ctrl_reg.internal_freq_sel;
          state_next   = IOS_ST_START;
        end
      // Same oscillator is already ready, so this passes at once
      IOS_ST_START:
        if (tgt_ready)
          state_next = IOS_ST_FALL;
      IOS_ST_FALL:
        if (!gate_reg || (int_clk_o && !acc_next[31]))
        begin
          gate_next      = 1'b0;
          gate_sync_next = 2'b00;
          acc_next       = 32'h0000_0000;
          cur_sel_next   = tgt_sel_reg;
          state_next     = IOS_ST_HOLD;
        end
      // Output held low until the synced gate meets a rising phase
      IOS_ST_HOLD:
      begin
        gate_sync_next = {gate_sync_reg[0], 1'b1};
        if (gate_sync_reg[1] && !acc_reg[31] && acc_next[31])
        begin
          gate_next  = 1'b1;
          state_next = IOS_ST_DONE;
        end
      end
      IOS_ST_DONE:
        state_next = IOS_ST_IDLE;
      default:
        state_next = IOS_ST_IDLE;
    endcase
    if (!int_mode)
      gate_next = 1'b0;
    clk_out_next = gate_next && acc_next[31] && rdy_reg[src_c];
  end

  // Status follows live flags except mid-switch, then lands at DONE
  always_comb
  begin
    status_next = status_o;
    if (state_reg == IOS_ST_IDLE || state_reg == IOS_ST_DONE)
    begin
      status_next.lf_ready_flag  = rdy_reg[IOS_SRC_LF];
      status_next.mf_ready_flag  = rdy_reg[IOS_SRC_MF];
      status_next.hf_ready_flag  = rdy_reg[IOS_SRC_HF];
      status_next.hf_locked_flag = rdy_reg[IOS_SRC_HF] &&
        hf_age_reg >= 32'(`IOS_HF_LOCK_CYC);
      status_next.hf_stable_flag = rdy_reg[IOS_SRC_HF] &&
        hf_age_reg >= 32'(`IOS_HF_STBL_CYC);
      status_next.mult_locked    = mult_lock_reg;
    end
    status_next.busy = (state_next != IOS_ST_IDLE);
  end

  // --------------------------------------------------------------------
  // Pins
  // --------------------------------------------------------------------
  // Secondary pin carries the clock only when the active-low bit is low
  always_comb
  begin
    prim_next = (cfg_i.osc_config_sel == `IOS_CFG_INTERNAL);
    if (prim_next && !cfg_i.clock_out_enable_n)
    begin
      sec_pin_next = clk_out_next;
      sec_oe_next  = 1'b1;
    end
    else
    begin
      sec_pin_next = sec_gpio_d_i;
      sec_oe_next  = sec_gpio_oe_i;
    end
  end

  // --------------------------------------------------------------------
  // Register bus slave
  // --------------------------------------------------------------------
  // One wait cycle: data is built, then waitrequest drops for one cycle
  assign req      = avs_read_i || avs_write_i;
  assign hit_ctrl = (avs_address_i == `IOS_ADDR_CTRL);
  assign hit_trim = (avs_address_i == `IOS_ADDR_TRIM);
  assign hit_stat = (avs_address_i == `IOS_ADDR_STATUS);

  always_comb
  begin
    ctrl_next  = ctrl_reg;
    trim_next  = trim_reg;
    wait_next  = 1'b1;
    rdata_next = rdata_reg;
    if (req && wait_reg)
    begin
      wait_next  = 1'b0;
      rdata_next = 32'h0000_0000;  // Unmapped reads return zero
      if (hit_ctrl)
        rdata_next = {24'h0, ctrl_reg};
      else if (hit_trim)
        rdata_next = {27'h0, trim_reg};
      else if (hit_stat)
        rdata_next = {25'h0, status_o};
    end
    else if (avs_write_i && !wait_reg && avs_byteenable_i[0])
    begin
      if (hit_ctrl)
      begin
        ctrl_next      = ios_ctrl_t'(avs_writedata_i[7:0]);
        ctrl_next.rsvd = 1'b0;
      end
      else if (hit_trim)
        trim_next = avs_writedata_i[4:0];
    end
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      ctrl_reg          <= '{sw_multiplier_enable: 1'b0,
                             internal_freq_sel: `IOS_FREQ_SEL_RST,
                             rsvd: 1'b0,
                             sys_clk_source_sel: `IOS_SRC_SEL_RST};
      trim_reg          <= `IOS_TRIM_RST;
      trim_eff_reg      <= `IOS_TRIM_RST;
      trim_cnt_reg      <= 32'h0000_0000;
      wait_reg          <= 1'b1;
      rdata_reg         <= 32'h0000_0000;
      for (int i = 0; i < 3; i++)
        start_cnt_reg[i] <= 32'h0000_0000;
      rdy_reg           <= 3'b000;
      hf_age_reg        <= 32'h0000_0000;
      mult_cnt_reg      <= 32'h0000_0000;
      mult_lock_reg     <= 1'b0;
      state_reg         <= IOS_ST_START;
      cur_sel_reg       <= `IOS_FREQ_SEL_RST;
      tgt_sel_reg       <= `IOS_FREQ_SEL_RST;
      acc_reg           <= 32'h0000_0000;
      lf_acc_reg        <= 32'h0000_0000;
      gate_reg          <= 1'b0;
      gate_sync_reg     <= 2'b00;
      int_clk_o         <= 1'b0;
      lf_clk_o          <= 1'b0;
      sec_pin_o         <= 1'b0;
      sec_pin_oe_o      <= 1'b0;
      prim_pin_gpio_o   <= 1'b0;
      status_o          <= '0;
    end
    else if (ce_i)
    begin
      ctrl_reg          <= ctrl_next;
      trim_reg          <= trim_next;
      trim_eff_reg      <= trim_eff_next;
      trim_cnt_reg      <= trim_cnt_next;
      wait_reg          <= wait_next;
      rdata_reg         <= rdata_next;
      for (int i = 0; i < 3; i++)
        start_cnt_reg[i] <= start_cnt_next[i];
      rdy_reg           <= rdy_next;
      hf_age_reg        <= hf_age_next;
      mult_cnt_reg      <= mult_cnt_next;
      mult_lock_reg     <= mult_lock_next;
      state_reg         <= state_next;
      cur_sel_reg       <= cur_sel_next;
      tgt_sel_reg       <= tgt_sel_next;
      acc_reg           <= acc_next;
      lf_acc_reg        <= lf_acc_next;
      gate_reg          <= gate_next;
      gate_sync_reg     <= gate_sync_next;
      int_clk_o         <= clk_out_next;
      lf_clk_o          <= lf_acc_next[31];
      sec_pin_o         <= sec_pin_next;
      sec_pin_oe_o      <= sec_oe_next;
      prim_pin_gpio_o   <= prim_next;
      status_o          <= status_next;
    end
  end

  assign avs_readdata_o    = rdata_reg;
  assign avs_waitrequest_o = wait_reg;

endmodule

`default_nettype wire

// ---- rtl/ios_pkg.sv ----
package ios_pkg;

  // Oscillator that feeds a frequency selection
  typedef enum logic [1:0] {
    IOS_SRC_LF = 2'b00,
    IOS_SRC_MF = 2'b01,
    IOS_SRC_HF = 2'b10
  } ios_src_t;

  // Clock switch sequence
  typedef enum logic [2:0] {
    IOS_ST_IDLE  = 3'b000,
    IOS_ST_START = 3'b001,
    IOS_ST_FALL  = 3'b010,
    IOS_ST_HOLD  = 3'b011,
    IOS_ST_DONE  = 3'b100
  } ios_state_t;

  // Software control word
  typedef struct packed {
    logic       sw_multiplier_enable;
    logic [3:0] internal_freq_sel;
    logic       rsvd;
    logic [1:0] sys_clk_source_sel;
  } ios_ctrl_t;

  // Oscillator status flags
  typedef struct packed {
    logic busy;
    logic mult_locked;
    logic hf_stable_flag;
    logic hf_locked_flag;
    logic hf_ready_flag;
    logic mf_ready_flag;
    logic lf_ready_flag;
  } ios_status_t;

  // Static configuration-word settings
  typedef struct packed {
    logic [2:0] osc_config_sel;
    logic       cfg_multiplier_enable;
    logic       clock_out_enable_n;
  } ios_cfg_t;

endpackage

// ---- rtl/ios_regs.svh ----
`ifndef IOS_REGS_SVH
`define IOS_REGS_SVH

// ----------------------------------------------------------------------
// Register map (byte addresses on the register bus)
// ----------------------------------------------------------------------
`define IOS_ADDR_CTRL          4'h0
`define IOS_ADDR_TRIM          4'h4
`define IOS_ADDR_STATUS        4'h8

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define IOS_CTRL_SRC_LSB       0
`define IOS_CTRL_FREQ_LSB      3
`define IOS_CTRL_MULT_BIT      7
`define IOS_FREQ_SEL_RST       4'h7
`define IOS_SRC_SEL_RST        2'h0
`define IOS_TRIM_RST           5'h00
`define IOS_CFG_INTERNAL       3'h4
`define IOS_ST_LF_RDY_BIT      0
`define IOS_ST_MF_RDY_BIT      1
`define IOS_ST_HF_RDY_BIT      2
`define IOS_ST_HF_LOCK_BIT     3
`define IOS_ST_HF_STBL_BIT     4
`define IOS_ST_MULT_LOCK_BIT   5
`define IOS_ST_BUSY_BIT        6

// ----------------------------------------------------------------------
// Timing: figures in ns, counts in 200 MHz cycles
// ----------------------------------------------------------------------
`define IOS_CLK_HZ             64'd200000000
`define IOS_CLK_MHZ            200
`define IOS_MF_START_NS        2000
`define IOS_MF_START_CYC       ((`IOS_MF_START_NS*`IOS_CLK_MHZ+999)/1000)
`define IOS_HF_START_NS        2000
`define IOS_HF_START_CYC       ((`IOS_HF_START_NS*`IOS_CLK_MHZ+999)/1000)
`define IOS_LF_START_NS        32258
`define IOS_LF_START_CYC       ((`IOS_LF_START_NS*`IOS_CLK_MHZ+999)/1000)
`define IOS_HF_LOCK_NS         4000
`define IOS_HF_LOCK_CYC        ((`IOS_HF_LOCK_NS*`IOS_CLK_MHZ+999)/1000)
`define IOS_HF_STBL_NS         10000
`define IOS_HF_STBL_CYC        ((`IOS_HF_STBL_NS*`IOS_CLK_MHZ+999)/1000)
`define IOS_MULT_LOCK_NS       2000000
`define IOS_MULT_LOCK_CYC      ((`IOS_MULT_LOCK_NS*`IOS_CLK_MHZ+999)/1000)
`define IOS_TRIM_STEP_NS       1000
`define IOS_TRIM_STEP_CYC      ((`IOS_TRIM_STEP_NS*`IOS_CLK_MHZ+999)/1000)

`endif

// ---- tb/ios_osc_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module ios_osc_chk
  import ios_pkg::*;
#(
  parameter logic [31:0] LF_START_CYC = 32'h8
) (
  input wire logic                sys_clk_i,
  input wire logic                srst_i,
  input wire logic                ce_i,
  input wire ios_pkg::ios_cfg_t   cfg_i,
  input wire logic                wdt_en_i,
  input wire logic                sec_gpio_d_i,
  input wire logic                sec_gpio_oe_i,
  input wire logic                avs_read_i,
  input wire logic                avs_write_i,
  input wire logic                avs_waitrequest_o,
  input wire logic                sec_pin_o,
  input wire logic                sec_pin_oe_o,
  input wire logic                prim_pin_gpio_o,
  input wire ios_pkg::ios_status_t status_o
);
  import ios_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  logic [31:0] wdt_cnt_reg;
  logic [31:0] wdt_cnt_next;
  // Saturating run length of the watchdog request
  always_comb
    wdt_cnt_next = !wdt_en_i ? 32'h0 : wdt_cnt_reg + 32'(wdt_cnt_reg < 32'hFF);
  always_ff @(posedge sys_clk_i)
    wdt_cnt_reg <= srst_i ? 32'h0 : wdt_cnt_next;
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  wait_one_a: assert property (ce_i && (avs_read_i || avs_write_i)
    && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("Bus wait");
  wait_pulse_a: assert property (ce_i && !avs_waitrequest_o
    |=> avs_waitrequest_o) else $error("Bus answer held");
  prim_gpio_a: assert property (ce_i |=> prim_pin_gpio_o ==
    ($past(cfg_i.osc_config_sel) == 3'h4)) else $error("Primary pin");
  sec_gpio_a: assert property (ce_i && cfg_i.clock_out_enable_n
    |=> sec_pin_oe_o == $past(sec_gpio_oe_i)
    && sec_pin_o == $past(sec_gpio_d_i))
    else $error("Secondary pin");
  lf_keep_a: assert property (wdt_cnt_reg >= LF_START_CYC + 32'h8
    && !status_o.busy && $past(status_o.busy) == 1'b0
    |-> status_o.lf_ready_flag) else $error("LF stopped");
  hf_lock_a: assert property (status_o.hf_locked_flag
    |-> status_o.hf_ready_flag) else $error("Lock without ready");
  hf_stable_a: assert property (status_o.hf_stable_flag
    |-> status_o.hf_locked_flag) else $error("Stable without lock");
  flag_hold_a: assert property (status_o.busy
    && $past(status_o.busy) |-> $stable(status_o[4:0]))
    else $error("Flags moved in switch");
endmodule
bind ios_internal_osc_select_switch ios_osc_chk #(.LF_START_CYC(LF_START_CYC))
  u_chk (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .ce_i(ce_i), .cfg_i(cfg_i),
  .wdt_en_i(wdt_en_i), .sec_gpio_d_i(sec_gpio_d_i),
  .sec_gpio_oe_i(sec_gpio_oe_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .sec_pin_o(sec_pin_o), .sec_pin_oe_o(sec_pin_oe_o),
  .prim_pin_gpio_o(prim_pin_gpio_o), .status_o(status_o));
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import ios_pkg::*;
  logic        sys_clk_i, srst_i, wdt_en, gpio_d, gpio_oe, rd_q, wr_q;
  logic [3:0]  addr_q, be_q;
  logic [31:0] wdata_q, rdata, q;
  logic        wait_q, int_clk, lf_clk, pin, pin_oe, prim;
  ios_status_t status;
  ios_cfg_t    cfg;
  int          n_mismatch, compares, n;
  ios_internal_osc_select_switch #(.LF_START_CYC(32'h8),
    .MULT_LOCK_CYC(32'h10)) dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i),
    .ce_i(1'b1), .cfg_i(cfg), .wdt_en_i(wdt_en), .failsafe_clock_monitor_en_i(1'b0),
    .sec_gpio_d_i(gpio_d), .sec_gpio_oe_i(gpio_oe), .avs_address_i(addr_q),
    .avs_read_i(rd_q), .avs_write_i(wr_q), .avs_writedata_i(wdata_q),
    .avs_byteenable_i(be_q), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wait_q), .int_clk_o(int_clk), .lf_clk_o(lf_clk),
    .sec_pin_o(pin), .sec_pin_oe_o(pin_oe), .prim_pin_gpio_o(prim),
    .status_o(status));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Holds the request until waitrequest is seen low, then idles a cycle
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    k = 0;
    wr_q <= w;
    rd_q <= !w;
    addr_q <= a;
    wdata_q <= d;
    be_q <= be;
    do
    begin
      @(posedge sys_clk_i);
      k++;
    end
    while (wait_q !== 1'b0 && k < 100);
    q = rdata;
    wr_q <= 1'b0;
    rd_q <= 1'b0;
    if (k >= 100)
    begin
      n_mismatch++;
      end_sim();
    end
    @(posedge sys_clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, a, 32'h0, 4'hF);
    chk(nm, q, e);
  endtask
  // Waits out a clock switch; n holds the busy cycles left after the four-cycle pause
  task automatic sw(input logic [31:0] ctrl);
    bus(1'b1, 4'h0, ctrl, 4'h1);
    repeat (4) @(posedge sys_clk_i);
    n = 0;
    while (status.busy !== 1'b0 && n < 5000)
    begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 5000)
    begin
      n_mismatch++;
      end_sim();
    end
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic rises(input int cyc, input int lo, input int hi);
    int r;
    logic p;
    r = 0;
    p = int_clk;
    repeat (cyc)
    begin
      @(posedge sys_clk_i);
      r += int'(p === 1'b0 && int_clk === 1'b1);
      p = int_clk;
    end
    chk("int_clk rises", 32'(r >= lo && r <= hi), 32'h1);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_defaults;
    rd(4'h0, 32'h38, "ctrl reset");
    rd(4'h4, 32'h0, "trim reset");
    chk("prim gpio", prim, 1'b1);
    repeat (500) @(posedge sys_clk_i);
    rises(800, 1, 3);
  endtask
  task automatic t_regs;
    bus(1'b1, 4'h0, 32'h3E, 4'h1);
    rd(4'h0, 32'h3A, "ctrl bit2");
    bus(1'b1, 4'h4, 32'h0F, 4'h1);
    rd(4'h4, 32'h0F, "trim max");
    bus(1'b1, 4'h4, 32'h10, 4'h1);
    bus(1'b1, 4'h4, 32'h05, 4'h0);
    rd(4'h4, 32'h10, "trim min");
    bus(1'b1, 4'hC, 32'hFF, 4'hF);
    rd(4'hC, 32'h0, "unmapped");
    bus(1'b1, 4'h4, 32'h00, 4'h1);  // Nominal rate for later counts
  endtask
  task automatic t_hf;
    sw(32'h7A);
    chk("hf ready only", 32'(status[4:2]), 32'h1);
    repeat (2100) @(posedge sys_clk_i);
    chk("hf flags", 32'(status[4:2]), 32'h7);
    rises(250, 19, 21);
    sw(32'h72);
    chk("same source fast", 32'(n < 100), 32'h1);
    rises(250, 9, 11);
    sw(32'hF2);
    // Same selection, so no switch: give the multiplier time to lock
    repeat (20) @(posedge sys_clk_i);
    chk("mult locked", status.mult_locked, 1'b1);
    rises(250, 39, 41);
    // Trim glides one code per step, so the first window is still nominal
    bus(1'b1, 4'h4, 32'h0F, 4'h1);
    rises(250, 39, 41);
    repeat (3100) @(posedge sys_clk_i);
    rises(250, 43, 46);
  endtask
  task automatic t_lf;
    sw(32'h02);
    chk("lf ready", status.lf_ready_flag, 1'b1);
    chk("hf off", status.hf_ready_flag, 1'b0);
    chk("lf clk", lf_clk, 1'b1);
    sw(32'h3A);
    chk("lf off", status.lf_ready_flag, 1'b0);
    chk("lf clk off", lf_clk, 1'b0);
    chk("mf ready", status.mf_ready_flag, 1'b1);
    wdt_en <= 1'b1;
    gpio_d <= 1'b1;
    gpio_oe <= 1'b1;
    repeat (40) @(posedge sys_clk_i);
    chk("lf for wdt", status.lf_ready_flag, 1'b1);
  endtask
  // Active-low clock-out bit hands the secondary pin to the clock
  task automatic t_clkout;
    cfg <= 5'h10;
    repeat (2) @(posedge sys_clk_i);
    chk("clkout oe", pin_oe, 1'b1);
    repeat (400)
    begin
      @(posedge sys_clk_i);
      chk("clkout pin", pin, int_clk);
    end
  endtask
  // A second reset in mid-run must bring the defaults back
  task automatic t_reset;
    srst_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    rd(4'h0, 32'h38, "ctrl after reset");
    rd(4'h4, 32'h0, "trim after reset");
  endtask
  initial
  begin
    {n_mismatch, compares} = '0;
    {wdt_en, gpio_d, gpio_oe, rd_q, wr_q} = '0;
    {addr_q, be_q, wdata_q} = '0;
    cfg = 5'h11;
    srst_i = 1'b1;
    repeat (10) @(posedge sys_clk_i);
    chk("wait in reset", wait_q, 1'b1);
    srst_i <= 1'b0;
    t_defaults();
    t_regs();
    t_hf();
    t_lf();
    t_clkout();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
